// [rtl/mem_ctrl.sv]
/*
 * Host controller for a stacked boot-block flash and pseudo-static RAM on shared pins.
 * Software issues single word reads and writes through APB registers; the block
 * drives the asynchronous strobes. Assumes pins are wired directly to the package.
 */
// Functional notes
// - Low address shared; flash gets two own upper bits, RAM one own bit.
// - Only one die may drive the shared data lines at once.
// - Flash reset low means power-down; held high for all operations. Here the pin follows CTRL_FRST, which resets low, and cycles are not blocked.
// - Flash output strobe and write strobe never low together.
// - One erase or program at a time; host waits, no queue.
// - Command write address lies inside the targeted block.
module mem_ctrl
   import mem_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // APB slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // Shared and per-die address pins, shared data pins
   output logic [16:0] ADDR_LOW_OUT,
   output logic [1:0] ADDR_MID_OUT,
   output logic FLASH_UPPER_ADDR_A_OUT,
   output logic FLASH_UPPER_ADDR_B_OUT,
   output logic RAM_UPPER_ADDR_OUT,
   input wire logic [15:0] DQ_IN,
   output logic [15:0] DQ_OUT,
   output logic [15:0] DQ_OE_OUT,
   // Flash controls
   output logic FLASH_CE_N_OUT,
   output logic FLASH_OE_N_OUT,
   output logic FLASH_WE_N_OUT,
   output logic FLASH_RST_N_OUT,
   output logic FLASH_WP_N_OUT,
   input wire logic FLASH_BUSY_FLAG_N_IN,
   // RAM controls
   output logic RAM_SELECT_N_OUT,
   output logic RAM_SLEEP_CTRL_OUT,
   output logic RAM_OE_N_OUT,
   output logic RAM_WE_N_OUT,
   output logic RAM_LOW_LANE_N_OUT,
   output logic RAM_HIGH_LANE_N_OUT
);
   cyc_state_t state_reg;
   logic [4:0] ctrl_reg;
   logic [20:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic op_write_reg;
   logic op_ram_reg;
   logic op_pe_reg;
   logic pe_active_reg;
   logic refused_reg;
   logic [2:0] cnt_reg;
   logic apb_wr;
   logic apb_rd;
   logic go;
   logic flash_busy;
   pin_sync_if pins ();

   assign pins.busy_raw_n = FLASH_BUSY_FLAG_N_IN;
   assign pins.dq_raw = DQ_IN;

   pin_sync u_sync (
      .clk_in(CLK_IN),
      .nrst_in(NRST_IN),
      .pins(pins)
   );

   assign flash_busy = ~pins.busy_n;
   assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
   assign apb_rd = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
   assign go = apb_wr && (PADDR_IN == ADDR_CMD) && PWDATA_IN[CMD_GO]
      && (state_reg == ST_IDLE);

   // ****************************************
   // APB slave
   // ****************************************
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         PREADY_OUT <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT <= 32'h0;
      end else begin
         PREADY_OUT <= PSEL_IN & ~PENABLE_IN;
         PSLVERR_OUT <= 1'b0;
         if (apb_rd) begin
            case (PADDR_IN)
               ADDR_CTRL: PRDATA_OUT <= {27'h0, ctrl_reg};
               ADDR_ADDR: PRDATA_OUT <= {11'h0, addr_reg};
               ADDR_WDATA: PRDATA_OUT <= {16'h0, wdata_reg};
               ADDR_RDATA: PRDATA_OUT <= {16'h0, rdata_reg};
               ADDR_STAT: PRDATA_OUT <= {29'h0, refused_reg, flash_busy,
                  state_reg != ST_IDLE};
               default: PRDATA_OUT <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ctrl_reg <= CTRL_RESET;
         addr_reg <= 21'h0;
         wdata_reg <= 16'h0;
      end else if (apb_wr) begin
         case (PADDR_IN)
            ADDR_CTRL: ctrl_reg <= PWDATA_IN[4:0];
            ADDR_ADDR: addr_reg <= PWDATA_IN[20:0];
            ADDR_WDATA: wdata_reg <= PWDATA_IN[15:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Bus cycle sequencer
   // ****************************************
   // busy check
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         op_write_reg <= 1'b0;
         op_ram_reg <= 1'b0;
         op_pe_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else if (go) begin
         op_write_reg <= PWDATA_IN[CMD_WRITE];
         op_ram_reg <= PWDATA_IN[CMD_RAM];
         op_pe_reg <= PWDATA_IN[CMD_PE];
         refused_reg <= PWDATA_IN[CMD_PE] & ~PWDATA_IN[CMD_RAM] & (flash_busy | pe_active_reg);
      end
   end

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         pe_active_reg <= 1'b0;
      end else if (state_reg == ST_HOLD && op_pe_reg && !op_ram_reg && !refused_reg) begin
         pe_active_reg <= 1'b1;
      end else if (!flash_busy && state_reg == ST_IDLE && cnt_reg == 3'h0) begin
         pe_active_reg <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 3'h0;
         rdata_reg <= 16'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (cnt_reg != 3'h0) begin
                  cnt_reg <= cnt_reg - 3'h1;
               end
               if (go && !(PWDATA_IN[CMD_PE] && !PWDATA_IN[CMD_RAM]
                  && (flash_busy || pe_active_reg))) begin
                  state_reg <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               state_reg <= ST_STROBE;
               cnt_reg <= 3'(ACCESS_CYC + 2);
            end
            ST_STROBE: begin
               if (cnt_reg == 3'h0) begin
                  state_reg <= ST_HOLD;
                  rdata_reg <= pins.dq;
               end else begin
                  cnt_reg <= cnt_reg - 3'h1;
               end
            end
            ST_HOLD: begin
               state_reg <= ST_IDLE;
               cnt_reg <= 3'h3;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ADDR_LOW_OUT <= 17'h0;
         ADDR_MID_OUT <= 2'h0;
         FLASH_UPPER_ADDR_A_OUT <= 1'b0;
         FLASH_UPPER_ADDR_B_OUT <= 1'b0;
         RAM_UPPER_ADDR_OUT <= 1'b0;
      end else begin
         ADDR_LOW_OUT <= addr_reg[16:0];
         ADDR_MID_OUT <= addr_reg[19:18];
         FLASH_UPPER_ADDR_A_OUT <= addr_reg[17];
         FLASH_UPPER_ADDR_B_OUT <= addr_reg[20];
         RAM_UPPER_ADDR_OUT <= addr_reg[17];
      end
   end

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         FLASH_CE_N_OUT <= 1'b1;
         FLASH_OE_N_OUT <= 1'b1;
         FLASH_WE_N_OUT <= 1'b1;
         RAM_SELECT_N_OUT <= 1'b1;
         RAM_OE_N_OUT <= 1'b1;
         RAM_WE_N_OUT <= 1'b1;
         DQ_OUT <= 16'h0;
         DQ_OE_OUT <= 16'h0;
      end else begin
         FLASH_CE_N_OUT <= ~((state_reg != ST_IDLE) && !op_ram_reg) | ~state_active();
         RAM_SELECT_N_OUT <= ~((state_reg != ST_IDLE) && op_ram_reg) | ~state_active();
         FLASH_OE_N_OUT <= ~(state_reg == ST_STROBE && !op_ram_reg && !op_write_reg);
         FLASH_WE_N_OUT <= ~(state_reg == ST_STROBE && !op_ram_reg && op_write_reg);
         RAM_OE_N_OUT <= ~(state_reg == ST_STROBE && op_ram_reg && !op_write_reg);
         RAM_WE_N_OUT <= ~(state_reg == ST_STROBE && op_ram_reg && op_write_reg);
         DQ_OUT <= wdata_reg;
         DQ_OE_OUT <= {16{state_active() && op_write_reg}};
      end
   end

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         FLASH_RST_N_OUT <= 1'b0;
         FLASH_WP_N_OUT <= 1'b0;
         RAM_SLEEP_CTRL_OUT <= 1'b1;
         RAM_LOW_LANE_N_OUT <= 1'b1;
         RAM_HIGH_LANE_N_OUT <= 1'b1;
      end else begin
         FLASH_RST_N_OUT <= ctrl_reg[CTRL_FRST];
         FLASH_WP_N_OUT <= ctrl_reg[CTRL_WP];
         RAM_SLEEP_CTRL_OUT <= ctrl_reg[CTRL_SLEEP];
         RAM_LOW_LANE_N_OUT <= ~ctrl_reg[CTRL_LB];
         RAM_HIGH_LANE_N_OUT <= ~ctrl_reg[CTRL_UB];
      end
   end

   // Select and data drive stay on through the hold state. The write strobe then rises
   // while the die is still selected and the data still stand, so the word is latched.
   function automatic logic state_active();
      return (state_reg == ST_SETUP) || (state_reg == ST_STROBE) || (state_reg == ST_HOLD);
   endfunction : state_active

   // ****************************************
   // Assertions
   // ****************************************
   a_strobe_excl: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      !(!FLASH_OE_N_OUT && !FLASH_WE_N_OUT)) else $error("flash strobes both low");
   a_one_die: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      !(!FLASH_CE_N_OUT && !RAM_SELECT_N_OUT)) else $error("both dies selected");
   a_dq_contend: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      (DQ_OE_OUT != 16'h0) |-> (FLASH_OE_N_OUT && RAM_OE_N_OUT))
      else $error("host drives data during a read");
   a_busy_refuse: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      (go && flash_busy && PWDATA_IN[CMD_PE] && !PWDATA_IN[CMD_RAM]) |=> state_reg == ST_IDLE)
      else $error("program started while busy");
   a_pe_single: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      (go && pe_active_reg && PWDATA_IN[CMD_PE] && !PWDATA_IN[CMD_RAM]) |=> refused_reg)
      else $error("second program not refused");
   a_rst_follow: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      $changed(ctrl_reg[CTRL_FRST]) |=> FLASH_RST_N_OUT == $past(ctrl_reg[CTRL_FRST]))
      else $error("flash reset pin lags control");
   a_sleep_follow: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      NRST_IN |=> RAM_SLEEP_CTRL_OUT == $past(ctrl_reg[CTRL_SLEEP]))
      else $error("sleep pin wrong");
   a_lane_follow: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      NRST_IN |=> RAM_LOW_LANE_N_OUT != $past(ctrl_reg[CTRL_LB])
      && RAM_HIGH_LANE_N_OUT != $past(ctrl_reg[CTRL_UB])) else $error("lane pin wrong");
   a_addr_split: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      NRST_IN |=> RAM_UPPER_ADDR_OUT == $past(addr_reg[17])
      && FLASH_UPPER_ADDR_B_OUT == $past(addr_reg[20]))
      else $error("address split wrong");
   a_cycle_len: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      (state_reg == ST_SETUP) |=> ##[1:8] state_reg == ST_HOLD) else $error("cycle too long");

   c_flash_read: cover property (@(posedge CLK_IN) !FLASH_OE_N_OUT);
   c_flash_write: cover property (@(posedge CLK_IN) !FLASH_WE_N_OUT);
   c_ram_write: cover property (@(posedge CLK_IN) !RAM_WE_N_OUT);
   c_refused: cover property (@(posedge CLK_IN) refused_reg);

endmodule : mem_ctrl

// [rtl/mem_ctrl_pkg.sv]
/*
 * Shared constants for the stacked flash and RAM bus controller: APB register map,
 * field positions, reset values and the pin timing counts.
 * Assumes a 25 MHz system clock and a device that needs 85 ns read access.
 */
package mem_ctrl_pkg;

   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int ACCESS_NS = 85;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************
   // Array sizes
   // ****************************************
   localparam int FLASH_WORDS = 2097152;
   localparam int RAM_WORDS = 1048576;
   localparam int FLASH_AW = 21;
   localparam int RAM_AW = 20;
   localparam int PARAM_BLOCKS = 8;
   localparam int PARAM_BLOCK_WORDS = 4096;
   localparam int MAIN_BLOCKS = 63;
   localparam int MAIN_BLOCK_WORDS = 32768;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_ADDR = 8'h04;
   localparam logic [7:0] ADDR_WDATA = 8'h08;
   localparam logic [7:0] ADDR_RDATA = 8'h0c;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam logic [7:0] ADDR_CMD = 8'h14;

   // Control register fields.
   localparam int CTRL_FRST = 0;
   localparam int CTRL_WP = 1;
   localparam int CTRL_SLEEP = 2;
   localparam int CTRL_LB = 3;
   localparam int CTRL_UB = 4;
   localparam logic [4:0] CTRL_RESET = 5'h1c;

   // Command register fields.
   localparam int CMD_GO = 0;
   localparam int CMD_WRITE = 1;
   localparam int CMD_RAM = 2;
   localparam int CMD_PE = 3;

   // Status register fields.
   localparam int STAT_BUSY = 0;
   localparam int STAT_FBUSY = 1;
   localparam int STAT_REFUSED = 2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_STROBE = 4'b0100,
      ST_HOLD = 4'b1000
   } cyc_state_t;

endpackage : mem_ctrl_pkg

// [rtl/pin_sync.sv]
/*
 * Two-stage synchroniser for the asynchronous pins read back from the package.
 * Assumes the pins may change at any time relative to the clock.
 */
module pin_sync (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Pins
   pin_sync_if.syncer pins
);
   logic [16:0] stage1_reg;
   logic [16:0] stage2_reg;

   // ****************************************
   // Synchroniser
   // ****************************************
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         stage1_reg <= 17'h10000;
         stage2_reg <= 17'h10000;
      end else begin
         stage1_reg <= {pins.busy_raw_n, pins.dq_raw};
         stage2_reg <= stage1_reg;
      end
   end

   assign pins.busy_n = stage2_reg[16];
   assign pins.dq = stage2_reg[15:0];

endmodule : pin_sync

// [rtl/pin_sync_if.sv]
/*
 * Interface between the controller core and its pin synchroniser.
 * Assumes both ends run on the same clock.
 */
interface pin_sync_if;
   logic busy_raw_n;
   logic busy_n;
   logic [15:0] dq_raw;
   logic [15:0] dq;
   modport syncer (input busy_raw_n, input dq_raw, output busy_n, output dq);
   modport core (output busy_raw_n, output dq_raw, input busy_n, input dq);
endinterface : pin_sync_if

// [verification/flash_ram_model.sv]
/*
 * Behavioural pin model of the stacked flash and RAM package.
 * Assumes a pull-up on the busy line and that the bench merges the data lines.
 */
module flash_ram_model #(
   parameter int BUSY_NS = 3000
) (
   // Flash pins
   input wire logic [20:0] f_addr_in,
   input wire logic f_ce_n_in,
   input wire logic f_oe_n_in,
   input wire logic f_we_n_in,
   input wire logic f_rst_n_in,
   // RAM pins
   input wire logic [19:0] r_addr_in,
   input wire logic r_sel_n_in,
   input wire logic r_sleep_in,
   input wire logic r_oe_n_in,
   input wire logic r_we_n_in,
   input wire logic r_lb_n_in,
   input wire logic r_ub_n_in,
   // Shared data and busy
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic busy_n_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] flash_mem [int];
   logic [15:0] ram_mem [int];
   logic [15:0] rd;
   logic [15:0] oe;
   logic [15:0] last;
   logic [15:0] t;
   initial begin
      busy_n_out = 1'b1;
      last = 16'h0;
   end
   // ********
   // Writes
   // ********
   // every block taken as unlocked; no lock command is sent
   // one partition, write-protect and supply monitor never lock here
   // no suspend is sent, so busy is only driven low or released
   // status is read from the controller, never from the array
   always @(posedge f_we_n_in) begin
      if (!f_ce_n_in && f_rst_n_in) begin
         flash_mem[int'(f_addr_in)] = dq_in;
         busy_n_out = 1'b0;
         busy_n_out <= #BUSY_NS 1'b1;
      end
   end
   always @(posedge r_we_n_in) begin
      if (!r_sel_n_in && r_sleep_in) begin
         t = ram_mem.exists(int'(r_addr_in)) ? ram_mem[int'(r_addr_in)] : 16'h0;
         if (!r_lb_n_in) t[7:0] = dq_in[7:0];
         if (!r_ub_n_in) t[15:8] = dq_in[15:8];
         ram_mem[int'(r_addr_in)] = t;
      end
   end
   // ********
   // Reads
   // ********
   // read drive
   always @* begin
      oe = 16'h0;
      rd = 16'h0;
      if (!f_ce_n_in && !f_oe_n_in && f_rst_n_in) begin
         oe = 16'hffff;
         if (flash_mem.exists(int'(f_addr_in))) rd = flash_mem[int'(f_addr_in)];
      end else if (!r_sel_n_in && r_sleep_in && !r_oe_n_in) begin
         oe = {{8{!r_ub_n_in}}, {8{!r_lb_n_in}}};
         if (ram_mem.exists(int'(r_addr_in))) rd = ram_mem[int'(r_addr_in)];
      end
   end
   // Released lines show the inverse of their last driven level.
   always @(oe or rd) begin
      last = (oe & rd) | (~oe & last);
      dq_out = (oe & rd) | (~oe & ~last);
   end
endmodule : flash_ram_model

// [verification/stacked_flash_pram_bus_port_tb.sv]
/*
 * Self-checking bench for mem_ctrl with the package model on its pins.
 * Assumes the register map and timing of the controller package.
 */
module stacked_flash_pram_bus_port_tb;
   import mem_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [20:0] ADDR_A = 21'h162345;
   localparam logic [20:0] ADDR_B = 21'h001000;
   logic clk, nrst, psel, penable, pwrite, pready;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [16:0] addr_low;
   logic [1:0] addr_mid;
   logic fa_a, fa_b, ra, f_ce_n, f_oe_n, f_we_n, f_rst_n, f_wp_n, busy_n;
   logic r_sel_n, r_sleep, r_oe_n, r_we_n, r_lb_n, r_ub_n;
   logic [15:0] dq_in, dq_out, dq_oe, m_dq;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int we_falls = 0;
   assign dq_in = (dq_oe & dq_out) | (~dq_oe & m_dq);
   mem_ctrl mem_ctrl_i (.CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(), .ADDR_LOW_OUT(addr_low), .ADDR_MID_OUT(addr_mid),
      .FLASH_UPPER_ADDR_A_OUT(fa_a), .FLASH_UPPER_ADDR_B_OUT(fa_b), .RAM_UPPER_ADDR_OUT(ra),
      .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_OUT(dq_oe), .FLASH_CE_N_OUT(f_ce_n),
      .FLASH_OE_N_OUT(f_oe_n), .FLASH_WE_N_OUT(f_we_n), .FLASH_RST_N_OUT(f_rst_n),
      .FLASH_WP_N_OUT(f_wp_n), .FLASH_BUSY_FLAG_N_IN(busy_n), .RAM_SELECT_N_OUT(r_sel_n),
      .RAM_SLEEP_CTRL_OUT(r_sleep), .RAM_OE_N_OUT(r_oe_n), .RAM_WE_N_OUT(r_we_n),
      .RAM_LOW_LANE_N_OUT(r_lb_n), .RAM_HIGH_LANE_N_OUT(r_ub_n));
   flash_ram_model flash_ram_model_i (.f_addr_in({fa_b, addr_mid, fa_a, addr_low}),
      .f_ce_n_in(f_ce_n), .f_oe_n_in(f_oe_n), .f_we_n_in(f_we_n), .f_rst_n_in(f_rst_n),
      .r_addr_in({addr_mid, ra, addr_low}), .r_sel_n_in(r_sel_n), .r_sleep_in(r_sleep),
      .r_oe_n_in(r_oe_n), .r_we_n_in(r_we_n), .r_lb_n_in(r_lb_n), .r_ub_n_in(r_ub_n),
      .dq_in(dq_out), .dq_out(m_dq), .busy_n_out(busy_n));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ********
   // Shared tasks
   // ********
   task chk(input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk
   task summarize;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task mem_op(input logic [20:0] a, input logic [15:0] d, input logic [3:0] cmd);
      apb(1'b1, ADDR_ADDR, {11'h0, a});
      apb(1'b1, ADDR_WDATA, {16'h0, d});
      apb(1'b1, ADDR_CMD, {28'h0, cmd});
      do begin
         apb(1'b0, ADDR_STAT, 32'h0);
      end while (rdata[STAT_BUSY] !== 1'b0);
      if (!cmd[CMD_WRITE]) apb(1'b0, ADDR_RDATA, 32'h0);
      rdata = {16'h0, rdata[15:0]};
   endtask : mem_op
   task wait_flash;
      do begin
         apb(1'b0, ADDR_STAT, 32'h0);
      end while (rdata[STAT_FBUSY] !== 1'b0);
   endtask : wait_flash
   task set_ctrl(input logic [4:0] v);
      apb(1'b1, ADDR_CTRL, {27'h0, v});
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk({27'h0, v}, rdata);
   endtask : set_ctrl
   // ********
   // Scenarios
   // ********
   task t_reset;
      chk(32'h4, {27'h0, f_rst_n, f_wp_n, r_sleep, r_lb_n, r_ub_n});
      chk(32'h3f, {26'h0, f_ce_n, f_oe_n, f_we_n, r_sel_n, r_oe_n, r_we_n});
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk({27'h0, CTRL_RESET}, rdata);
      apb(1'b1, 8'h20, 32'hffffffff);
      apb(1'b0, 8'h20, 32'h0);
      chk(32'h0, rdata);
   endtask : t_reset
   task t_ram_lanes;
      set_ctrl(5'h1f);
      chk(32'h1c, {27'h0, f_rst_n, f_wp_n, r_sleep, r_lb_n, r_ub_n});
      mem_op(ADDR_A, 16'h1234, 4'h7);
      set_ctrl(5'h0f);
      mem_op(ADDR_A, 16'habcd, 4'h7);
      set_ctrl(5'h1f);
      mem_op(ADDR_A, 16'h0, 4'h5);
      chk(32'h12cd, rdata);
   endtask : t_ram_lanes
   task t_dies;
      mem_op(ADDR_A, 16'hbeef, 4'h3);
      wait_flash;
      mem_op(ADDR_A, 16'h0, 4'h1);
      chk(32'hbeef, rdata);
      mem_op(ADDR_A ^ 21'h100000, 16'h0, 4'h1);
      chk(32'h0, rdata);
      mem_op(ADDR_A ^ 21'h020000, 16'h0, 4'h1);
      chk(32'h0, rdata);
      mem_op(ADDR_A, 16'h0, 4'h5);
      chk(32'h12cd, rdata);
      mem_op(ADDR_A ^ 21'h020000, 16'h0, 4'h5);
      chk(32'h0, rdata);
   endtask : t_dies
   task t_sleep;
      set_ctrl(5'h1b);
      mem_op(ADDR_A, 16'h0, 4'h7);
      set_ctrl(5'h1f);
      mem_op(ADDR_A, 16'h0, 4'h5);
      chk(32'h12cd, rdata);
   endtask : t_sleep
   task t_refuse;
      int w;
      wait_flash;
      mem_op(ADDR_B, 16'h0f0f, 4'hb);
      w = we_falls;
      mem_op(ADDR_B, 16'hf0f0, 4'hb);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(32'h6, rdata & 32'h7);
      chk(32'(w), 32'(we_falls));
      wait_flash;
      mem_op(ADDR_B, 16'hf0f0, 4'hb);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(32'h2, rdata & 32'h7);
      chk(32'(w + 1), 32'(we_falls));
      wait_flash;
      mem_op(ADDR_B, 16'h0, 4'h1);
      chk(32'hf0f0, rdata);
   endtask : t_refuse
   always @(negedge f_we_n) begin
      if (nrst === 1'b1) we_falls++;
   end
   always @(posedge clk) begin
      cycles++;
      if (nrst === 1'b1) begin
         chk(32'h0, {29'h0, f_oe_n === 1'b0 && f_we_n === 1'b0,
            f_ce_n === 1'b0 && r_sel_n === 1'b0,
            (f_oe_n === 1'b0 || r_oe_n === 1'b0) && dq_oe !== 16'h0});
      end
      if (cycles == 20000) begin
         num_errors++;
         summarize;
      end
   end
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset;
      t_ram_lanes;
      t_dies;
      t_sleep;
      t_refuse;
      summarize;
   end
endmodule : stacked_flash_pram_bus_port_tb
